// *** lics_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module lics_host_model (
    // Clock and frame request
    input  wire logic clk,
    input  wire logic start,
    // Serial pins, pulled high when idle
    output logic      serial_clk_pin,
    output logic      serial_data_pin
);
    logic [6:0] cnt_q = 7'h00;
    logic       busy_q = 1'b0;

    // Frame of 8 clock periods, clock stands high between frames
    always_ff @(posedge clk) begin
        if (start && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q  <= 7'h00;
        end else if (busy_q) begin
            cnt_q  <= cnt_q + 7'h01;
            busy_q <= cnt_q != 7'h7F;
        end
    end

    assign serial_clk_pin = busy_q ? cnt_q[3] : 1'b1;
    assign serial_data_pin = busy_q ? cnt_q[4] ^ (cnt_q[3:0] == 4'h4) : 1'b1;
endmodule

`default_nettype wire

// *** lics_pkg.sv ***
package lics_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ            = 20000000;
    localparam int unsigned CLK_PERIOD_NS     = 50;
    localparam int unsigned SPIKE_NS          = 50;
    localparam int unsigned SPIKE_CYCLES      =
        (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TICK_US           = 1000;
    localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000000 * TICK_US;
    localparam int unsigned TIMEOUT_MIN_TENTH = 56;
    localparam int unsigned TIMEOUT_TICKS     =
        TIMEOUT_MIN_TENTH * 360 * 1000;

    // APB register map (byte addresses)
    localparam logic [7:0] ADDR_CHARGE_CFG = 8'h00;
    localparam logic [7:0] ADDR_EOC_CFG    = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_SERIAL_CMD = 8'h0C;

    // Charge config fields
    localparam int unsigned CUR_CODE_LSB  = 0;
    localparam int unsigned CUR_CODE_W    = 4;
    localparam int unsigned VREG_SEL_BIT  = 4;
    localparam int unsigned EOC_SEL_LSB   = 0;
    localparam int unsigned EOC_SEL_W     = 2;

    // Current codes: 100 mA + 50 mA per step, max 750 mA
    localparam logic [3:0] CUR_CODE_RESET = 4'h8;
    localparam logic [3:0] CUR_CODE_MAX   = 4'hD;
    localparam logic [9:0] CUR_BASE_MA    = 10'h064;
    localparam logic [9:0] CUR_STEP_MA    = 10'h032;
    localparam logic [9:0] USB_LOW_MA     = 10'h064;
    localparam logic [9:0] PRECHG_MA      = 10'h032;

    // End-of-charge codes
    localparam logic [1:0] EOC_0P10 = 2'h0;
    localparam logic [1:0] EOC_0P15 = 2'h1;
    localparam logic [1:0] EOC_0P20 = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_PREQUAL,
        PH_CONST_I,
        PH_CONST_V,
        PH_MAINT,
        PH_FAULT
    } lics_phase_type;

    typedef struct packed {
        logic supply_ok;
        logic adaptor_ok;
        logic batt_above_qual;
        logic batt_at_reg;
        logic batt_below_restart;
        logic current_below_eoc;
        logic temp_ok;
        logic retain_ok;
    } lics_sense_type;

    typedef struct packed {
        logic [9:0] charge_current_ma;
        logic       vreg_high;
        logic [1:0] eoc_sel;
        logic       charging;
        logic       charge_done;
        logic       fault;
    } lics_ctrl_type;

endpackage

// *** lics_sequencer.sv ***
// What this block does
// - Prequalify only with supply and adaptor good
// - Prequalify drives small safe current only
// - Above 3.0V move to constant current
// - AC source uses 500mA or programmed
// - USB source starts at 100mA
// - Safety timer starts entering constant current
// - Timer expiry in constant current stops
// - Regulation level reached enters constant voltage
// - Current below threshold raises charge done
// - End threshold 0.1C, 0.15C, 0.2C selectable
// - Maintenance restarts on 200mV sag
// - Temperature out of range stops charging
// - Factory defaults used after power up
// - USB select high 100mA, low programmable
// - AC mode ignores current select pin
// - Serial inputs suppress 50ns spikes
// - Regulation default fixed by variant
// - Temperature recovery restarts sequence, timer, unless the timer has expired
// - Settings kept while battery above 2.85V
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module lics_sequencer #(
    parameter logic        VREG_DEFAULT_HIGH = 1'b1,
    parameter int unsigned TICK_CYCLES_P     = lics_pkg::TICK_CYCLES,
    parameter int unsigned TIMEOUT_TICKS_P   = lics_pkg::TIMEOUT_TICKS
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Analog comparator sense inputs
    input  wire lics_pkg::lics_sense_type sense,
    // Source selection pins
    input  wire logic                  ac_mode_pin,
    input  wire logic                  usb_current_select_pin,
    // Serial clock and data pins
    input  wire logic                  serial_clk_pin,
    input  wire logic                  serial_data_pin,
    // Controls to the charger
    output lics_pkg::lics_ctrl_type    ctrl,
    output logic                       serial_clk_clean,
    output logic                       serial_data_clean
);

    lics_pkg::lics_phase_type phase_q;
    lics_pkg::lics_sense_type s1_q, s2_q, s3_q, sense_q;
    logic [1:0] pin1_q, pin2_q, pin3_q, pin_q;
    logic [3:0] cur_code_q;
    logic       vreg_high_q;
    logic [1:0] eoc_sel_q;
    logic       timer_expired_q;
    logic [15:0] prescale_q;
    logic [31:0] timer_q;
    logic       tick;
    logic       temp_ok_prev_q;
    logic [1:0] spike_cnt_clk_q, spike_cnt_data_q;
    logic [9:0] cur_ma_d;
    logic       wr_en, rd_en;

    // Three-stage capture of asynchronous inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            sense_q <= '0;
            pin1_q  <= '0;
            pin2_q  <= '0;
            pin3_q  <= '0;
            pin_q   <= '0;
        end else begin
            s1_q   <= sense;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            pin1_q <= {ac_mode_pin, usb_current_select_pin};
            pin2_q <= pin1_q;
            pin3_q <= pin2_q;
            for (int i = 0; i < 8; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sense_q[i] <= s3_q[i];
                end
            end
            for (int j = 0; j < 2; j++) begin
                if (pin2_q[j] == pin3_q[j]) begin
                    pin_q[j] <= pin3_q[j];
                end
            end
        end
    end

    // serial spike filter
    // A level must hold past the spike width before it is accepted
    logic [1:0] sc1_q, sc2_q, sc3_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc1_q             <= 2'h3;
            sc2_q             <= 2'h3;
            sc3_q             <= 2'h3;
            spike_cnt_clk_q   <= '0;
            spike_cnt_data_q  <= '0;
            serial_clk_clean  <= 1'b1;
            serial_data_clean <= 1'b1;
        end else begin
            sc1_q <= {serial_clk_pin, serial_data_pin};
            sc2_q <= sc1_q;
            sc3_q <= sc2_q;
            if (sc2_q[1] != sc3_q[1] || sc3_q[1] == serial_clk_clean) begin
                spike_cnt_clk_q <= '0;
            end else if (spike_cnt_clk_q >=
                         2'(lics_pkg::SPIKE_CYCLES)) begin
                serial_clk_clean <= sc3_q[1];
                spike_cnt_clk_q  <= '0;
            end else begin
                spike_cnt_clk_q <= spike_cnt_clk_q + 2'h1;
            end
            if (sc2_q[0] != sc3_q[0] || sc3_q[0] == serial_data_clean) begin
                spike_cnt_data_q <= '0;
            end else if (spike_cnt_data_q >=
                         2'(lics_pkg::SPIKE_CYCLES)) begin
                serial_data_clean <= sc3_q[0];
                spike_cnt_data_q  <= '0;
            end else begin
                spike_cnt_data_q <= spike_cnt_data_q + 2'h1;
            end
        end
    end

    // APB decode, zero-wait
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // Settings registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_code_q  <= lics_pkg::CUR_CODE_RESET;
            vreg_high_q <= VREG_DEFAULT_HIGH;
            eoc_sel_q   <= lics_pkg::EOC_0P10;
        end else if (!sense_q.retain_ok) begin
            cur_code_q  <= lics_pkg::CUR_CODE_RESET;
            vreg_high_q <= VREG_DEFAULT_HIGH;
            eoc_sel_q   <= lics_pkg::EOC_0P10;
        end else if (wr_en && paddr == lics_pkg::ADDR_CHARGE_CFG) begin
            if (pwdata[3:0] <= lics_pkg::CUR_CODE_MAX) begin
                cur_code_q <= pwdata[3:0];
            end
            vreg_high_q <= pwdata[lics_pkg::VREG_SEL_BIT];
        end else if (wr_en && paddr == lics_pkg::ADDR_EOC_CFG) begin
            if (pwdata[1:0] != 2'h3) begin
                eoc_sel_q <= pwdata[1:0];
            end
        end
    end

    // APB answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > lics_pkg::ADDR_STATUS;
            if (rd_en) begin
                case (paddr)
                    lics_pkg::ADDR_CHARGE_CFG:
                        prdata <= {27'h0, vreg_high_q, cur_code_q};
                    lics_pkg::ADDR_EOC_CFG:
                        prdata <= {30'h0, eoc_sel_q};
                    lics_pkg::ADDR_STATUS:
                        prdata <= {27'h0, timer_expired_q, 1'b0,
                                   3'(phase_q)};
                    default:
                        prdata <= '0;
                endcase
            end
        end
    end

    assign tick = (prescale_q == 16'(TICK_CYCLES_P - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_q <= '0;
        end else if (tick) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_q + 16'h0001;
        end
    end

    // Sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q         <= lics_pkg::PH_IDLE;
            timer_q         <= '0;
            timer_expired_q <= 1'b0;
            temp_ok_prev_q  <= 1'b0;
        end else begin
            temp_ok_prev_q <= sense_q.temp_ok;
            if (!sense_q.supply_ok || !sense_q.adaptor_ok) begin
                phase_q <= lics_pkg::PH_IDLE;
            end else if (!sense_q.temp_ok) begin
                phase_q <= lics_pkg::PH_FAULT;
            end else if (!temp_ok_prev_q && phase_q == lics_pkg::PH_FAULT
                         && !timer_expired_q) begin
                phase_q <= lics_pkg::PH_PREQUAL;
                timer_q <= '0;
            end else begin
                case (phase_q)
                    lics_pkg::PH_IDLE: begin
                        phase_q <= lics_pkg::PH_PREQUAL;
                    end
                    lics_pkg::PH_PREQUAL: begin
                        if (sense_q.batt_above_qual) begin
                            phase_q <= lics_pkg::PH_CONST_I;
                            timer_q <= '0;
                        end
                    end
                    lics_pkg::PH_CONST_I: begin
                        if (timer_q >= TIMEOUT_TICKS_P) begin
                            timer_expired_q <= 1'b1;
                            phase_q         <= lics_pkg::PH_FAULT;
                        end else if (sense_q.batt_at_reg) begin
                            phase_q <= lics_pkg::PH_CONST_V;
                        end else if (tick) begin
                            timer_q <= timer_q + 32'h1;
                        end
                    end
                    lics_pkg::PH_CONST_V: begin
                        if (sense_q.current_below_eoc) begin
                            phase_q <= lics_pkg::PH_MAINT;
                        end
                    end
                    lics_pkg::PH_MAINT: begin
                        if (sense_q.batt_below_restart) begin
                            phase_q <= lics_pkg::PH_PREQUAL;
                        end
                    end
                    lics_pkg::PH_FAULT: begin
                        phase_q <= lics_pkg::PH_FAULT;
                    end
                    default: begin
                        phase_q <= lics_pkg::PH_IDLE;
                    end
                endcase
            end
        end
    end

    // Charge current selection
    always_comb begin
        cur_ma_d = lics_pkg::CUR_BASE_MA
                 + 10'(cur_code_q * lics_pkg::CUR_STEP_MA);
        if (phase_q == lics_pkg::PH_PREQUAL) begin
            cur_ma_d = lics_pkg::PRECHG_MA;
        end else if (phase_q != lics_pkg::PH_CONST_I
                     && phase_q != lics_pkg::PH_CONST_V) begin
            cur_ma_d = '0;
        end else if (!pin_q[1] && pin_q[0]) begin
            cur_ma_d = lics_pkg::USB_LOW_MA;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else begin
            ctrl.charge_current_ma <= cur_ma_d;
            ctrl.vreg_high         <= vreg_high_q;
            ctrl.eoc_sel           <= eoc_sel_q;
            ctrl.charging          <= phase_q == lics_pkg::PH_PREQUAL
                                   || phase_q == lics_pkg::PH_CONST_I
                                   || phase_q == lics_pkg::PH_CONST_V;
            ctrl.charge_done       <= phase_q == lics_pkg::PH_MAINT;
            ctrl.fault             <= phase_q == lics_pkg::PH_FAULT;
        end
    end

endmodule

`default_nettype wire

// *** lics_sequencer_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module lics_sequencer_chk (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    // Pins and sense
    input wire logic                     ac_mode_pin,
    input wire logic                     usb_current_select_pin,
    input wire logic                     serial_clk_pin,
    input wire logic                     serial_data_pin,
    input wire lics_pkg::lics_sense_type sense,
    // Outputs
    input wire lics_pkg::lics_ctrl_type  ctrl,
    input wire logic                     serial_clk_clean,
    input wire logic                     serial_data_clean
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    supply_off_a: assert property (
        !sense.supply_ok [*8] |-> !ctrl.charging)
        else $error("charging without supply");
    temp_off_a: assert property (
        !sense.temp_ok [*8] |-> !ctrl.charging)
        else $error("charging with bad temperature");
    current_range_a: assert property (
        ctrl.charging |-> ctrl.charge_current_ma inside {[10'h032:10'h2EE]}
        && ctrl.charge_current_ma % 10'h032 == 10'h000)
        else $error("charge current off grid");
    usb_low_a: assert property (
        (!ac_mode_pin && usb_current_select_pin) [*8] ##0 ctrl.charging
        |-> ctrl.charge_current_ma <= 10'h064)
        else $error("usb select high above 100 mA");
    done_cause_a: assert property (
        $rose(ctrl.charge_done) |-> sense.current_below_eoc)
        else $error("done without low current");
    fault_stop_a: assert property (
        ctrl.fault |-> !ctrl.charging)
        else $error("charging during fault");
    clk_filter_a: assert property (
        $stable(serial_clk_pin) [*8] |-> serial_clk_clean == serial_clk_pin)
        else $error("clock filter output wrong");
    data_filter_a: assert property (
        $stable(serial_data_pin) [*8] |-> serial_data_clean == serial_data_pin)
        else $error("data filter output wrong");

    done_c: cover property ($rose(ctrl.charge_done));
    fault_c: cover property ($rose(ctrl.fault));
    usb_c: cover property (!ac_mode_pin && ctrl.charge_current_ma == 10'h064);
    frame_c: cover property ($fell(serial_clk_clean));
endmodule

bind lics_sequencer lics_sequencer_chk lics_sequencer_chk_inst (
    .clk(clk), .rst_n(rst_n), .ac_mode_pin(ac_mode_pin),
    .usb_current_select_pin(usb_current_select_pin),
    .serial_clk_pin(serial_clk_pin), .serial_data_pin(serial_data_pin),
    .sense(sense), .ctrl(ctrl), .serial_clk_clean(serial_clk_clean),
    .serial_data_clean(serial_data_clean)
);

`default_nettype wire

// *** lics_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module lics_sequencer_tb;
    logic                    clk, rst_n, psel, penable, pwrite, pready;
    logic                    pslverr, ac_mode_pin, usb_current_select_pin;
    logic                    start, s_clk, s_dat, c_clk, c_dat, err;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata, rd;
    lics_pkg::lics_sense_type sense;
    lics_pkg::lics_ctrl_type ctrl;
    int                      num_errors = 0;
    int                      n_tests = 0;
    int                      n_crise, n_dchg;

    // Short timer: 4 x 250 cycles
    lics_sequencer #(.TICK_CYCLES_P(4), .TIMEOUT_TICKS_P(250))
        lics_sequencer_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sense(sense),
        .ac_mode_pin(ac_mode_pin),
        .usb_current_select_pin(usb_current_select_pin),
        .serial_clk_pin(s_clk), .serial_data_pin(s_dat), .ctrl(ctrl),
        .serial_clk_clean(c_clk), .serial_data_clean(c_dat));
    lics_host_model lics_host_model_inst (.clk(clk), .start(start),
        .serial_clk_pin(s_clk), .serial_data_pin(s_dat));

    always #25 clk = ~clk;
    always @(posedge c_clk) n_crise++;
    always @(c_dat) n_dchg++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        cyc(4);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic st(input logic [31:0] e);
        cyc(12);
        rdc(lics_pkg::ADDR_STATUS, e);
    endtask

    function automatic logic [31:0] cur();
        return {22'h0, ctrl.charge_current_ma};
    endfunction

    task automatic summarize();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #1000000;
        num_errors++;
        $display("mismatch at %0t: timeout", $time);
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, start} = '0;
        {ac_mode_pin, usb_current_select_pin} = 2'h0;
        sense = '0;
        cyc(6);
        rst_n <= 1'b1;
        rdc(lics_pkg::ADDR_CHARGE_CFG, 32'h18);
        rdc(lics_pkg::ADDR_EOC_CFG, 32'h0);
        rdc(lics_pkg::ADDR_SERIAL_CMD, 32'h0);
        chk(err, 1'b1);
        n_crise = 0;
        n_dchg = 0;
        start <= 1'b1;
        cyc(1);
        start <= 1'b0;
        cyc(150);
        chk(n_crise, 8);
        chk(n_dchg, 8);
        ac_mode_pin <= 1'b1;
        sense <= 8'h83;
        st(32'h0);
        sense.adaptor_ok <= 1'b1;
        st(32'h1);
        chk(cur(), 32'h32);
        sense.batt_above_qual <= 1'b1;
        st(32'h2);
        chk(cur(), 32'h1F4);
        usb_current_select_pin <= 1'b1;
        cyc(12);
        chk(cur(), 32'h1F4);
        wr(lics_pkg::ADDR_CHARGE_CFG, 32'h0D);
        chk(cur(), 32'h2EE);
        chk(ctrl.vreg_high, 1'b0);
        wr(lics_pkg::ADDR_CHARGE_CFG, 32'h1E);
        chk(cur(), 32'h2EE);
        wr(lics_pkg::ADDR_CHARGE_CFG, 32'h10);
        chk(cur(), 32'h64);
        for (int i = 0; i < 4; i++) begin
            wr(lics_pkg::ADDR_EOC_CFG, 32'(i));
            chk(ctrl.eoc_sel, (i < 3) ? i : 2);
        end
        sense.batt_at_reg <= 1'b1;
        st(32'h3);
        sense.current_below_eoc <= 1'b1;
        st(32'h4);
        chk(ctrl.charge_done, 1'b1);
        sense <= 8'hE3;
        st(32'h4);
        sense <= 8'hCB;
        st(32'h1);
        sense.temp_ok <= 1'b0;
        st(32'h5);
        chk(ctrl.charging, 1'b0);
        sense <= 8'hC3;
        st(32'h1);
        sense.retain_ok <= 1'b0;
        cyc(6);
        wr(lics_pkg::ADDR_CHARGE_CFG, 32'h05);
        rdc(lics_pkg::ADDR_CHARGE_CFG, 32'h18);
        sense.retain_ok <= 1'b1;
        cyc(6);
        wr(lics_pkg::ADDR_CHARGE_CFG, 32'h05);
        rdc(lics_pkg::ADDR_CHARGE_CFG, 32'h05);
        wr(lics_pkg::ADDR_CHARGE_CFG, 32'h18);
        ac_mode_pin <= 1'b0;
        sense.batt_above_qual <= 1'b1;
        st(32'h2);
        chk(cur(), 32'h64);
        usb_current_select_pin <= 1'b0;
        cyc(12);
        chk(cur(), 32'h1F4);
        cyc(760);
        st(32'h2);
        cyc(300);
        st(32'h15);
        chk(ctrl.fault, 1'b1);
        wr(lics_pkg::ADDR_CHARGE_CFG, 32'h03);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        rdc(lics_pkg::ADDR_CHARGE_CFG, 32'h18);
        summarize();
    end
endmodule

`default_nettype wire
